// >>> inc/tsmc_params.svh
`ifndef TSMC_PARAMS_SVH
`define TSMC_PARAMS_SVH

// seven-bit target address 1001 110
`define TSMC_SMB_ADDR 7'h4E
// command codes
`define TSMC_CMD_CONFIG 8'h03
`define TSMC_CMD_TEMP 8'h01
`define TSMC_CMD_ONE_SHOT 8'h0F
// configuration register layout
`define TSMC_CFG_MASK_BIT 7
`define TSMC_CFG_STANDBY_BIT 6
`define TSMC_CFG_RESERVED_MSB 5
`define TSMC_CFG_RESET 8'h00
`define TSMC_TEMP_RESET 8'h00

`endif

// >>> inc/tsmc_pkg.sv
package tsmc_pkg;

    typedef enum logic [3:0] {
        TSMC_IDLE,
        TSMC_ADDR,
        TSMC_ACK_ADDR,
        TSMC_CMD,
        TSMC_ACK_CMD,
        TSMC_DATA,
        TSMC_ACK_DATA,
        TSMC_TX,
        TSMC_TX_ACK,
        TSMC_IGNORE
    } tsmc_bus_t;

    typedef enum logic {
        TSMC_CV_IDLE,
        TSMC_CV_RUN
    } tsmc_conv_st_t;

    typedef struct packed {
        tsmc_bus_t st;
        logic [2:0] bits;
        logic [7:0] sh;
        logic byte_done;
        logic rw;
        logic [7:0] cmd;
        logic [7:0] cfg;
        logic one_shot;
        logic sda_oe;
        logic sda_out;
        logic scl_q;
        logic sda_q;
    } tsmc_slave_t;

    typedef struct packed {
        tsmc_conv_st_t st;
        logic single;
        logic start;
        logic abort;
        logic [7:0] temp;
        logic over;
        logic alert_oe;
        logic alert_out;
    } tsmc_conv_t;

endpackage : tsmc_pkg

// >>> inc/tsmc_ctl_if.sv
`timescale 1ns/1ns
interface tsmc_ctl_if;
    logic standby;
    logic mask;
    logic one_shot;
    logic [7:0] temp;

    modport slave_mp (
        output standby,
        output mask,
        output one_shot,
        input temp
    );
    modport conv_mp (
        input standby,
        input mask,
        input one_shot,
        output temp
    );
endinterface : tsmc_ctl_if

// >>> core/tsmc_conv.sv
`timescale 1ns/1ns
`include "tsmc_params.svh"
module tsmc_conv
    import tsmc_pkg::*;
(
    input wire logic REF_CLK,
    input wire logic RESET_N,
    tsmc_ctl_if.conv_mp ctl,
    input wire logic CONV_DONE,
    input wire logic [7:0] CONV_RESULT,
    input wire logic [7:0] TEMP_HIGH_LIMIT,
    input wire logic [7:0] TEMP_LOW_LIMIT,
    output logic CONV_START,
    output logic CONV_ABORT,
    output logic SMB_ALERT_N_OUT,
    output logic SMB_ALERT_N_OE
);
    tsmc_conv_t c;
    tsmc_conv_t next_c;
    logic beyond;

    assign beyond = (CONV_RESULT > TEMP_HIGH_LIMIT) || (CONV_RESULT < TEMP_LOW_LIMIT);

    always_comb begin
        next_c = c;
        next_c.start = 1'b0;
        next_c.abort = 1'b0;
        next_c.alert_out = 1'b0;
        case (c.st)
            TSMC_CV_IDLE: begin
                if (!ctl.standby) begin
                    next_c.start = 1'b1;
                    next_c.single = 1'b0;
                    next_c.st = TSMC_CV_RUN;
                end else if (ctl.one_shot) begin
                    next_c.start = 1'b1;
                    next_c.single = 1'b1;
                    next_c.st = TSMC_CV_RUN;
                end
            end
            TSMC_CV_RUN: begin
                // a one-shot in progress is allowed to finish in standby
                if (ctl.standby && !c.single) begin
                    next_c.abort = 1'b1;
                    next_c.st = TSMC_CV_IDLE;
                end else if (CONV_DONE) begin
                    next_c.temp = CONV_RESULT;
                    next_c.over = beyond;
                    next_c.st = TSMC_CV_IDLE;
                end
            end
            default: next_c.st = TSMC_CV_IDLE;
        endcase
        next_c.alert_oe = next_c.over && !ctl.mask;
    end

    always_ff @(posedge REF_CLK) begin
        if (!RESET_N) begin
            c <= '{st: TSMC_CV_IDLE, temp: `TSMC_TEMP_RESET, default: '0};
        end else begin
            c <= next_c;
        end
    end

    assign ctl.temp = c.temp;
    assign CONV_START = c.start;
    assign CONV_ABORT = c.abort;
    assign SMB_ALERT_N_OUT = c.alert_out;
    assign SMB_ALERT_N_OE = c.alert_oe;

    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!RESET_N);

    sequence s_done_auto;
        c.st == TSMC_CV_RUN && CONV_DONE && !ctl.standby;
    endsequence
    sequence s_restart;
        // standby landing in the idle cycle legitimately holds the restart back
        !c.start ##1 (c.start || $past(ctl.standby));
    endsequence

    property p_auto_restart;
        s_done_auto |=> s_restart;
    endproperty
    a_auto_restart: assert property (p_auto_restart) else $error("auto mode did not restart conversion");

    property p_standby_abort;
        (c.st == TSMC_CV_RUN && ctl.standby && !c.single) |=> c.abort ##1 (!c.start || $past(ctl.one_shot));
    endproperty
    a_standby_abort: assert property (p_standby_abort) else $error("standby did not abort");

    property p_one_shot;
        (c.st == TSMC_CV_IDLE && ctl.standby && ctl.one_shot) |=> c.start && c.single;
    endproperty
    a_one_shot: assert property (p_one_shot) else $error("one-shot did not start a conversion");

    property p_standby_quiet;
        (c.st == TSMC_CV_IDLE && ctl.standby && !ctl.one_shot) |=> !c.start;
    endproperty
    a_standby_quiet: assert property (p_standby_quiet) else $error("conversion started in standby");

    property p_mask;
        ctl.mask |=> !SMB_ALERT_N_OE;
    endproperty
    a_mask: assert property (p_mask) else $error("alert driven while masked");

    property p_alert;
        (c.st == TSMC_CV_RUN && CONV_DONE && !(ctl.standby && !c.single) && beyond && !ctl.mask)
            |=> SMB_ALERT_N_OE && !SMB_ALERT_N_OUT;
    endproperty
    a_alert: assert property (p_alert) else $error("alert missing after threshold crossing");
endmodule : tsmc_conv

// >>> core/tsmc_top.sv
`timescale 1ns/1ns
`include "tsmc_params.svh"
// How it works
// - The sensor answers as an SMBus target only at address 1001 110 and ignores all other transactions.
// - The configuration register is eight bits, mask at bit 7, standby at bit 6, bits 5-0 reserved, reset to zero.
// - With the standby bit at zero the sensor converts continuously without further commands.
// - Writing the standby bit to one aborts conversion at once and stops automatic conversions.
// - In standby each one-shot command that arrives with no conversion running runs exactly one conversion; one arriving mid-conversion is dropped.
// - A one-shot during continuous mode has no guaranteed result and the host must not rely on it.
// - While the mask bit is one the alert output stays deasserted whatever the temperature.
// - The alert output is asserted when a measured temperature lies beyond either threshold.
module tsmc_top
    import tsmc_pkg::*;
(
    input wire logic REF_CLK,
    input wire logic RESET_N,
    input wire logic SMB_CLK_IN,
    input wire logic SMB_DATA_IN,
    output logic SMB_DATA_OUT,
    output logic SMB_DATA_OE,
    output logic SMB_ALERT_N_OUT,
    output logic SMB_ALERT_N_OE,
    input wire logic CONV_DONE,
    input wire logic [7:0] CONV_RESULT,
    input wire logic [7:0] TEMP_HIGH_LIMIT,
    input wire logic [7:0] TEMP_LOW_LIMIT,
    output logic CONV_START,
    output logic CONV_ABORT
);
    tsmc_slave_t s;
    tsmc_slave_t next_s;
    tsmc_ctl_if ctl ();
    logic rise;
    logic fall;
    logic start_cond;
    logic stop_cond;
    logic [7:0] rd_val;

    // value returned for a read; reserved bits always read back as zero
    function automatic logic [7:0] read_value(input logic [7:0] cmd, input logic [7:0] cfg,
                                              input logic [7:0] temp);
        logic [7:0] v;
        v = 8'h00;
        if (cmd == `TSMC_CMD_CONFIG) begin
            v[`TSMC_CFG_MASK_BIT] = cfg[`TSMC_CFG_MASK_BIT];
            v[`TSMC_CFG_STANDBY_BIT] = cfg[`TSMC_CFG_STANDBY_BIT];
        end else if (cmd == `TSMC_CMD_TEMP) begin
            v = temp;
        end
        return v;
    endfunction : read_value

    assign rise = SMB_CLK_IN && !s.scl_q;
    assign fall = !SMB_CLK_IN && s.scl_q;
    assign start_cond = s.scl_q && SMB_CLK_IN && s.sda_q && !SMB_DATA_IN;
    assign stop_cond = s.scl_q && SMB_CLK_IN && !s.sda_q && SMB_DATA_IN;
    assign rd_val = read_value(s.cmd, s.cfg, ctl.temp);

    always_comb begin
        next_s = s;
        next_s.one_shot = 1'b0;
        next_s.sda_out = 1'b0;
        next_s.scl_q = SMB_CLK_IN;
        next_s.sda_q = SMB_DATA_IN;
        if (start_cond) begin
            // repeated start lands here too, keeping the command byte
            next_s.st = TSMC_ADDR;
            next_s.bits = 3'h0;
            next_s.byte_done = 1'b0;
            next_s.sda_oe = 1'b0;
        end else if (stop_cond) begin
            next_s.st = TSMC_IDLE;
            next_s.sda_oe = 1'b0;
        end else begin
            case (s.st)
                TSMC_ADDR, TSMC_CMD, TSMC_DATA: begin
                    if (rise) begin
                        next_s.sh = {s.sh[6:0], SMB_DATA_IN};
                        next_s.bits = s.bits + 3'h1;
                        if (s.bits == 3'h7) begin
                            next_s.byte_done = 1'b1;
                        end
                    end else if (fall && s.byte_done) begin
                        next_s.byte_done = 1'b0;
                        next_s.bits = 3'h0;
                        if (s.st == TSMC_ADDR) begin
                            if (s.sh[7:1] == `TSMC_SMB_ADDR) begin
                                next_s.rw = s.sh[0];
                                next_s.sda_oe = 1'b1;
                                next_s.st = TSMC_ACK_ADDR;
                            end else begin
                                next_s.st = TSMC_IGNORE;
                            end
                        end else if (s.st == TSMC_CMD) begin
                            next_s.cmd = s.sh;
                            // one-shot in continuous mode is still passed on; the converter drops it
                            next_s.one_shot = (s.sh == `TSMC_CMD_ONE_SHOT);
                            next_s.sda_oe = 1'b1;
                            next_s.st = TSMC_ACK_CMD;
                        end else begin
                            if (s.cmd == `TSMC_CMD_CONFIG) begin
                                // reserved bits are not stored, so a careless host cannot wake them
                                next_s.cfg = {s.sh[`TSMC_CFG_MASK_BIT:`TSMC_CFG_STANDBY_BIT], 6'h00};
                            end
                            next_s.sda_oe = 1'b1;
                            next_s.st = TSMC_ACK_DATA;
                        end
                    end
                end
                TSMC_ACK_ADDR: begin
                    if (fall) begin
                        if (s.rw) begin
                            next_s.sh = rd_val;
                            next_s.sda_oe = !rd_val[7];
                            next_s.st = TSMC_TX;
                        end else begin
                            next_s.sda_oe = 1'b0;
                            next_s.st = TSMC_CMD;
                        end
                    end
                end
                TSMC_ACK_CMD, TSMC_ACK_DATA: begin
                    if (fall) begin
                        next_s.sda_oe = 1'b0;
                        next_s.st = TSMC_DATA;
                    end
                end
                TSMC_TX: begin
                    if (rise) begin
                        next_s.bits = s.bits + 3'h1;
                        if (s.bits == 3'h7) begin
                            next_s.byte_done = 1'b1;
                        end
                    end else if (fall) begin
                        if (s.byte_done) begin
                            next_s.byte_done = 1'b0;
                            next_s.bits = 3'h0;
                            next_s.sda_oe = 1'b0;
                            next_s.st = TSMC_TX_ACK;
                        end else begin
                            next_s.sh = {s.sh[6:0], 1'b0};
                            next_s.sda_oe = !s.sh[6];
                        end
                    end
                end
                TSMC_TX_ACK: begin
                    // byte_done reused as the host's acknowledge
                    if (rise) begin
                        next_s.byte_done = !SMB_DATA_IN;
                    end else if (fall) begin
                        next_s.byte_done = 1'b0;
                        if (s.byte_done) begin
                            next_s.sh = rd_val;
                            next_s.sda_oe = !rd_val[7];
                            next_s.st = TSMC_TX;
                        end else begin
                            next_s.st = TSMC_IGNORE;
                        end
                    end
                end
                TSMC_IDLE, TSMC_IGNORE: begin
                    next_s.sda_oe = 1'b0;
                end
                default: begin
                    next_s.st = TSMC_IDLE;
                    next_s.sda_oe = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (!RESET_N) begin
            s <= '{st: TSMC_IDLE, cfg: `TSMC_CFG_RESET, scl_q: 1'b1, sda_q: 1'b1, default: '0};
        end else begin
            s <= next_s;
        end
    end

    assign ctl.standby = s.cfg[`TSMC_CFG_STANDBY_BIT];
    assign ctl.mask = s.cfg[`TSMC_CFG_MASK_BIT];
    assign ctl.one_shot = s.one_shot;
    assign SMB_DATA_OUT = s.sda_out;
    assign SMB_DATA_OE = s.sda_oe;

    tsmc_conv u_conv (
        .REF_CLK(REF_CLK),
        .RESET_N(RESET_N),
        .ctl(ctl.conv_mp),
        .CONV_DONE(CONV_DONE),
        .CONV_RESULT(CONV_RESULT),
        .TEMP_HIGH_LIMIT(TEMP_HIGH_LIMIT),
        .TEMP_LOW_LIMIT(TEMP_LOW_LIMIT),
        .CONV_START(CONV_START),
        .CONV_ABORT(CONV_ABORT),
        .SMB_ALERT_N_OUT(SMB_ALERT_N_OUT),
        .SMB_ALERT_N_OE(SMB_ALERT_N_OE)
    );

    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!RESET_N);

    sequence s_addr_byte_end;
        s.st == TSMC_ADDR && !start_cond && !stop_cond && fall && s.byte_done;
    endsequence

    property p_foreign_addr;
        (s_addr_byte_end and s.sh[7:1] != `TSMC_SMB_ADDR) |=> s.st == TSMC_IGNORE && !SMB_DATA_OE;
    endproperty
    a_foreign_addr: assert property (p_foreign_addr) else $error("answered a foreign address");

    property p_own_addr;
        (s_addr_byte_end and s.sh[7:1] == `TSMC_SMB_ADDR) |=> SMB_DATA_OE && s.st == TSMC_ACK_ADDR;
    endproperty
    a_own_addr: assert property (p_own_addr) else $error("own address not acknowledged");

    property p_reserved_zero;
        s.cfg[`TSMC_CFG_RESERVED_MSB:0] == 6'h00;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits not zero");

    property p_cfg_read;
        (s.st == TSMC_ACK_ADDR && fall && s.rw && s.cmd == `TSMC_CMD_CONFIG && !start_cond && !stop_cond)
            |=> s.sh == {s.cfg[`TSMC_CFG_MASK_BIT:`TSMC_CFG_STANDBY_BIT], 6'h00} && s.st == TSMC_TX;
    endproperty
    a_cfg_read: assert property (p_cfg_read) else $error("config read value wrong");

    property p_one_shot_cmd;
        (s.st == TSMC_CMD && fall && s.byte_done && s.sh == `TSMC_CMD_ONE_SHOT && !start_cond && !stop_cond)
            |=> s.one_shot ##1 !s.one_shot;
    endproperty
    a_one_shot_cmd: assert property (p_one_shot_cmd) else $error("one-shot command not issued once");
endmodule : tsmc_top

// >>> tb/tsmc_host.sv
`timescale 1ns/1ns
module tsmc_host (
    input wire logic REF_CLK,
    input wire logic SDA_IN,
    output logic SCL,
    output logic SDA
);
    initial begin
        SCL = 1'h1;
        SDA = 1'h1;
    end

    task automatic half();
        repeat (8) @(posedge REF_CLK);
    endtask : half

    // works from idle and as a repeated start with the clock low
    task automatic start_c();
        @(posedge REF_CLK) SDA <= 1'h1;
        half();
        SCL <= 1'h1;
        half();
        SDA <= 1'h0;
        half();
        SCL <= 1'h0;
    endtask : start_c

    task automatic stop_c();
        @(posedge REF_CLK) SDA <= 1'h0;
        half();
        SCL <= 1'h1;
        half();
        SDA <= 1'h1;
        half();
    endtask : stop_c

    // data moves one cycle after the clock fall, sampled at the end of the high phase
    task automatic bit_c(input logic b, output logic r);
        @(posedge REF_CLK) SDA <= b;
        half();
        SCL <= 1'h1;
        half();
        r = SDA_IN;
        SCL <= 1'h0;
    endtask : bit_c

    task automatic byte_c(input logic [7:0] d, output logic [7:0] q, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_c(d[i], r);
            q[i] = r;
        end
        bit_c(1'h1, r);
        ack = ~r;
    endtask : byte_c

    task automatic write(input logic [6:0] a, input logic [7:0] cmd, input logic [7:0] data,
                         input logic with_data, output logic ack);
        logic [7:0] q;
        logic k;
        start_c();
        byte_c({a, 1'h0}, q, ack);
        byte_c(cmd, q, k);
        ack = ack & k;
        if (with_data) begin
            byte_c(data & 8'hC0, q, k);
            ack = ack & k;
        end
        stop_c();
    endtask : write

    // reserved bits of the answer are dropped by the caller
    task automatic read(input logic [6:0] a, input logic [7:0] cmd, output logic [7:0] data, output logic ack);
        logic [7:0] q;
        logic k;
        logic r;
        start_c();
        byte_c({a, 1'h0}, q, ack);
        byte_c(cmd, q, k);
        ack = ack & k;
        start_c();
        byte_c({a, 1'h1}, q, k);
        ack = ack & k;
        for (int i = 7; i >= 0; i--) begin
            bit_c(1'h1, r);
            data[i] = r;
        end
        bit_c(1'h1, r);
        stop_c();
    endtask : read
endmodule : tsmc_host

// >>> tb/tsmc_top_test.sv
`timescale 1ns/1ns
`include "tsmc_params.svh"
module tsmc_top_test;
    logic ref_clk = 1'h0;
    logic reset_n = 1'h0;
    logic scl, host_sda, sda_in, data_out, data_oe, alert_out, alert_oe, conv_start, conv_abort;
    logic conv_done = 1'h0;
    logic busy = 1'h0;
    logic [7:0] conv_result = 8'h00;
    logic [7:0] high_limit = 8'h00;
    logic [7:0] low_limit = 8'h00;
    logic [7:0] next_result = 8'h00;
    logic [7:0] cfg_m = 8'h00;
    logic [7:0] result_q[$];
    logic [7:0] ra;
    logic [2:0] pipe = 3'h0;
    int conv_delay = 1500;
    int remain = 0;
    int starts = 0;
    int mismatches = 0;
    int checked = 0;

    initial begin
        forever #2 ref_clk = ~ref_clk;
    end

    // open drain with pull-up
    assign sda_in = host_sda & ~data_oe;

    tsmc_host host (.REF_CLK(ref_clk), .SDA_IN(sda_in), .SCL(scl), .SDA(host_sda));

    tsmc_top uut (
        .REF_CLK(ref_clk), .RESET_N(reset_n), .SMB_CLK_IN(scl), .SMB_DATA_IN(sda_in),
        .SMB_DATA_OUT(data_out), .SMB_DATA_OE(data_oe), .SMB_ALERT_N_OUT(alert_out),
        .SMB_ALERT_N_OE(alert_oe), .CONV_DONE(conv_done), .CONV_RESULT(conv_result),
        .TEMP_HIGH_LIMIT(high_limit), .TEMP_LOW_LIMIT(low_limit), .CONV_START(conv_start),
        .CONV_ABORT(conv_abort)
    );

    task automatic cmp(input string what, input logic [7:0] exp, input logic [7:0] got);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask : cmp

    task automatic final_report();
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : final_report

    // converter model; result bus scrambles outside a done pulse
    always @(posedge ref_clk) begin
        conv_done <= 1'h0;
        conv_result <= ~conv_result;
        if (conv_start === 1'h1) begin
            starts++;
            busy <= 1'h1;
            remain <= conv_delay;
        end else if (conv_abort === 1'h1) begin
            busy <= 1'h0;
        end else if (busy) begin
            remain <= remain - 1;
            if (remain == 1) begin
                conv_done <= 1'h1;
                conv_result <= next_result;
                busy <= 1'h0;
            end
        end
    end

    // alert model: strict compare, checked three edges after each result
    always @(posedge ref_clk) begin
        pipe <= {pipe[1:0], conv_done};
        if (conv_done === 1'h1) begin
            result_q.push_back(conv_result);
        end
        if (pipe[2]) begin
            ra = result_q.pop_front();
            cmp("alert", {7'h00, !cfg_m[7] && (ra > high_limit || ra < low_limit)}, {7'h00, alert_oe});
            cmp("alert_drive", 8'h00, {7'h00, alert_out});
        end
    end

    task automatic wr_cfg(input logic [7:0] v);
        logic ack;
        // mask model moves first: results can follow the landing before the stop ends
        cfg_m = v;
        host.write(`TSMC_SMB_ADDR, `TSMC_CMD_CONFIG, v, 1'h1, ack);
        cmp("config_ack", 8'h01, {7'h00, ack});
    endtask : wr_cfg

    task automatic rd_cfg();
        logic ack;
        logic [7:0] rd;
        host.read(`TSMC_SMB_ADDR, `TSMC_CMD_CONFIG, rd, ack);
        cmp("config_read", cfg_m, rd & 8'hC0);
        cmp("read_ack", 8'h01, {7'h00, ack});
        cmp("data_drive", 8'h00, {7'h00, data_out});
    endtask : rd_cfg

    // one-shots are only issued in standby, never relied on in continuous mode
    task automatic shot();
        logic ack;
        int s0;
        s0 = starts;
        host.write(`TSMC_SMB_ADDR, `TSMC_CMD_ONE_SHOT, 8'h00, 1'h0, ack);
        for (int i = 0; i < 200 && busy; i++) @(posedge ref_clk);
        repeat (6) @(posedge ref_clk);
        cmp("one_shot_starts", 8'h01, 8'(starts - s0));
    endtask : shot

    initial begin
        logic ack;
        logic [7:0] h;
        logic [7:0] l;
        int s0;
        void'($urandom(32'hD12C));
        repeat (6) @(posedge ref_clk);
        reset_n <= 1'h1;
        rd_cfg();
        repeat (4000) @(posedge ref_clk);
        cmp("continuous_starts", 8'h01, {7'h00, starts >= 2});
        $display("test reset_continuous done");
        host.write(`TSMC_SMB_ADDR ^ 7'h01, `TSMC_CMD_CONFIG, 8'h40, 1'h1, ack);
        cmp("foreign_ack", 8'h00, {7'h00, ack});
        rd_cfg();
        $display("test foreign_address done");
        wr_cfg(8'h40);
        repeat (2) @(posedge ref_clk);
        cmp("busy_after_standby", 8'h00, {7'h00, busy});
        s0 = starts;
        repeat (3000) @(posedge ref_clk);
        cmp("standby_starts", 8'h00, 8'(starts - s0));
        rd_cfg();
        $display("test standby done");
        conv_delay = 30;
        for (int i = 0; i < 8; i++) begin
            h = 8'($urandom_range(255, 128));
            l = 8'($urandom_range(127, 0));
            high_limit <= h;
            low_limit <= l;
            next_result <= (i == 0) ? h : (i == 1) ? l : 8'($urandom);
            shot();
        end
        $display("test one_shot_alert done");
        wr_cfg(8'hC0);
        rd_cfg();
        high_limit <= 8'h00;
        low_limit <= 8'hFF;
        for (int i = 0; i < 3; i++) begin
            next_result <= 8'($urandom);
            shot();
        end
        host.read(`TSMC_SMB_ADDR, `TSMC_CMD_TEMP, h, ack);
        cmp("temp_read", ra, h);
        $display("test mask done");
        s0 = starts;
        wr_cfg(8'h00);
        repeat (3500) @(posedge ref_clk);
        cmp("resume_starts", 8'h01, {7'h00, (starts - s0) >= 2});
        rd_cfg();
        $display("test resume done");
        final_report();
    end

    initial begin
        repeat (60000) @(posedge ref_clk);
        mismatches++;
        final_report();
    end
endmodule : tsmc_top_test
